// ==== csr_config_status_regs.sv ====
// Register bank top: serial bus slave, index and data window, drive config and status.
// Operation
// - Config bit 7 high takes settings from registers, low from preset pins.
// - Laser mode with register source: bias is 1 mA plus field times 0.4 mA.
// - Line driver mode with register source: field sets driver strength.
// - Keep an 8-bit read-only loss-of-lock tally as the first status byte.
// - With send enabled, send the tally whenever lock returns; always readable.
// - Status bits 7:6, 5:4, 3:2 show the three redundant link state copies.
// - Link state codes: 00 unlocked, 01 locked, 10 ready, 11 tally send.
// - Status bit 1 shows the protocol select pin.
// - Status bit 0 shows the narrow word pin.
// - A 3-bit index register written over the bus selects the target register.
// - Data window writes and reads reach the register the index selects.
// - Bus writes aimed at either status register are ignored.
// - Answer two addresses from six pins: low bit 0 index, 1 data.
// - Index 4 selects the loss-of-lock tally.
// - Register source select resets to 0 so preset pins rule.
`timescale 1ns/10ps
`default_nettype none
module csr_config_status_regs
  import csr_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [PIN_ADDR_W-1:0] i2cAddrPins,
  input wire logic laserModePin,
  input wire logic protocolSelectPin,
  input wire logic narrowWordPin,
  input wire logic [1:0] biasPresetPins,
  input wire csr_link_copies_type linkCopies,
  input wire logic unlockEvent,
  input wire logic lockRegained,
  input wire logic tallySendEnable,
  output logic regSourceSelect,
  output logic [FIELD_W-1:0] laserBiasField,
  output logic [CURRENT_W-1:0] biasCurrentUa,
  output logic [FIELD_W-1:0] lineDriverStrength,
  output logic [BYTE_W-1:0] unlockEventTally,
  output logic tallySendValid,
  output logic [BYTE_W-1:0] tallySendWord
);

  csr_line_events_type ev;
  csr_bus_state_type state_reg;
  csr_bus_write_type busWrite;
  logic [2:0] bitCnt_reg;
  logic byteDone_reg;
  logic [BYTE_W-1:0] shift_reg;
  logic slotIsData_reg;
  logic rwRead_reg;
  logic ackSeen_reg;
  logic sdaOe_reg;
  logic sdaOut_reg;
  logic [IDX_W-1:0] regIndex_reg;
  logic [BYTE_W-1:0] driveConfig_reg;
  logic regSourceSelect_reg;
  logic [FIELD_W-1:0] laserBiasField_reg;
  logic [CURRENT_W-1:0] biasCurrentUa_reg;
  logic [FIELD_W-1:0] lineDriverStrength_reg;
  logic [BYTE_W-1:0] tallyValue;
  logic [BYTE_W-1:0] linkStatus;
  logic [BYTE_W-1:0] readByte;
  logic [FIELD_W-1:0] fieldSelected;
  logic addrHit;
  logic inDataBits;

  csr_line_sampler u_sampler (
    .core_clk(core_clk),
    .reset(reset),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .events(ev)
  );

  csr_unlock_tally u_tally (
    .core_clk(core_clk),
    .reset(reset),
    .unlockEvent(unlockEvent),
    .lockRegained(lockRegained),
    .tallySendEnable(tallySendEnable),
    .unlockEventTally(tallyValue),
    .tallySendValid(tallySendValid),
    .tallySendWord(tallySendWord)
  );

  function automatic logic [BYTE_W-1:0] windowRead(input logic [IDX_W-1:0] idx,
                                                   input logic [BYTE_W-1:0] cfg,
                                                   input logic [BYTE_W-1:0] tally,
                                                   input logic [BYTE_W-1:0] status);
    case (idx)
      IDX_DRIVE_CFG: windowRead = cfg;
      IDX_TALLY: windowRead = tally;
      IDX_LINK_STATUS: windowRead = status;
      default: windowRead = READ_ZERO;
    endcase
  endfunction

  // Status byte is live, so a read shows the pins at the moment it is taken.
  assign linkStatus = {linkCopies.copyA, linkCopies.copyB, linkCopies.copyC,
                       protocolSelectPin,
                       narrowWordPin};
  assign readByte = slotIsData_reg ? windowRead(regIndex_reg, driveConfig_reg, tallyValue, linkStatus)
                                   : {INDEX_PAD, regIndex_reg};
  assign addrHit = (shift_reg[BYTE_W-1:2] == i2cAddrPins);
  assign inDataBits = (state_reg == ST_ADDR) || (state_reg == ST_WRITE) || (state_reg == ST_READ);

  always_comb begin
    busWrite.valid = (state_reg == ST_WRITE) && ev.sclFall && byteDone_reg;
    busWrite.dataSlot = slotIsData_reg;
    busWrite.data = shift_reg;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
    end else if (ev.stop) begin
      state_reg <= ST_IDLE;
    end else if (ev.start) begin
      state_reg <= ST_ADDR;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_reg <= ST_IDLE;
        end
        ST_ADDR: begin
          if (ev.sclFall && byteDone_reg) begin
            state_reg <= addrHit ? ST_ADDR_ACK : ST_IDLE;
          end
        end
        ST_ADDR_ACK: begin
          if (ev.sclFall) begin
            state_reg <= rwRead_reg ? ST_READ : ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (ev.sclFall && byteDone_reg) begin
            state_reg <= ST_WRITE_ACK;
          end
        end
        ST_WRITE_ACK: begin
          if (ev.sclFall) begin
            state_reg <= ST_WRITE;
          end
        end
        ST_READ: begin
          if (ev.sclFall && byteDone_reg) begin
            state_reg <= ST_READ_ACK;
          end
        end
        ST_READ_ACK: begin
          if (ev.sclRise && ev.sdaLevel) begin
            state_reg <= ST_IDLE;
          end else if (ev.sclFall && ackSeen_reg) begin
            state_reg <= ST_READ;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      bitCnt_reg <= BIT_FIRST;
    end else if (ev.start || ev.stop) begin
      bitCnt_reg <= BIT_FIRST;
    end else if (ev.sclRise && inDataBits) begin
      bitCnt_reg <= bitCnt_reg + 3'h1;
    end
  end

  // Done marks the eighth bit until the clock falls, which is where the address and write ack decisions are taken.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      byteDone_reg <= 1'b0;
    end else if (ev.start || ev.stop) begin
      byteDone_reg <= 1'b0;
    end else if (ev.sclRise && inDataBits) begin
      byteDone_reg <= (bitCnt_reg == BIT_LAST);
    end else if (ev.sclFall) begin
      byteDone_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      shift_reg <= READ_ZERO;
    end else if (ev.sclRise && (state_reg == ST_ADDR || state_reg == ST_WRITE)) begin
      shift_reg <= {shift_reg[BYTE_W-2:0], ev.sdaLevel};
    end else if (ev.sclFall && state_reg == ST_READ && !byteDone_reg) begin
      shift_reg <= {shift_reg[BYTE_W-2:0], 1'b0};
    end else if (ev.sclFall && state_reg == ST_ADDR_ACK && rwRead_reg) begin
      shift_reg <= readByte;
    end else if (ev.sclFall && state_reg == ST_READ_ACK && ackSeen_reg) begin
      shift_reg <= readByte;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      slotIsData_reg <= 1'b0;
    end else if (state_reg == ST_ADDR && ev.sclFall && byteDone_reg) begin
      slotIsData_reg <= shift_reg[1];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rwRead_reg <= 1'b0;
    end else if (state_reg == ST_ADDR && ev.sclFall && byteDone_reg) begin
      rwRead_reg <= shift_reg[0];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ackSeen_reg <= 1'b0;
    end else if (state_reg == ST_READ_ACK && ev.sclRise) begin
      ackSeen_reg <= !ev.sdaLevel;
    end else if (state_reg != ST_READ_ACK) begin
      ackSeen_reg <= 1'b0;
    end
  end

  // The line only changes while the clock is low, so a data bit never fakes a start or stop.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sdaOe_reg <= 1'b0;
    end else if (ev.start || ev.stop) begin
      sdaOe_reg <= 1'b0;
    end else if (ev.sclFall) begin
      case (state_reg)
        ST_ADDR: sdaOe_reg <= byteDone_reg && addrHit;
        ST_ADDR_ACK: sdaOe_reg <= rwRead_reg && !readByte[BYTE_W-1];
        ST_WRITE: sdaOe_reg <= byteDone_reg;
        ST_WRITE_ACK: sdaOe_reg <= 1'b0;
        ST_READ: sdaOe_reg <= !byteDone_reg && !shift_reg[BYTE_W-2];
        ST_READ_ACK: sdaOe_reg <= ackSeen_reg && !readByte[BYTE_W-1];
        default: sdaOe_reg <= 1'b0;
      endcase
    end
  end

  // The index stays put after a data access, so repeated reads need no new pointer write.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      regIndex_reg <= IDX_DRIVE_CFG;
    end else if (busWrite.valid && !busWrite.dataSlot) begin
      regIndex_reg <= busWrite.data[IDX_W-1:0];
    end
  end

  // Status and undefined indexes fall through with no store.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      driveConfig_reg <= DRIVE_CFG_RESET;
    end else if (busWrite.valid && busWrite.dataSlot && regIndex_reg == IDX_DRIVE_CFG) begin
      driveConfig_reg <= busWrite.data;
    end
  end

  assign fieldSelected = driveConfig_reg[CFG_SRC_BIT] ? driveConfig_reg[CFG_FIELD_MSB:0]
                                                      : presetCode(biasPresetPins);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      regSourceSelect_reg <= 1'b0;
    end else begin
      regSourceSelect_reg <= driveConfig_reg[CFG_SRC_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      laserBiasField_reg <= FIELD_ZERO;
    end else begin
      laserBiasField_reg <= laserModePin ? fieldSelected : FIELD_ZERO;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      biasCurrentUa_reg <= CURRENT_ZERO;
    end else begin
      biasCurrentUa_reg <= laserModePin ? BIAS_BASE_UA + CURRENT_W'(fieldSelected) * BIAS_STEP_UA
                                        : CURRENT_ZERO;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      lineDriverStrength_reg <= FIELD_ZERO;
    end else begin
      lineDriverStrength_reg <= laserModePin ? FIELD_ZERO : fieldSelected;
    end
  end

  // The data line is open drain: it only ever pulls low, so its value register holds a constant low.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sdaOut_reg <= 1'b0;
    end else begin
      sdaOut_reg <= 1'b0;
    end
  end

  assign sdaOut = sdaOut_reg;
  assign sdaOe = sdaOe_reg;
  assign regSourceSelect = regSourceSelect_reg;
  assign laserBiasField = laserBiasField_reg;
  assign biasCurrentUa = biasCurrentUa_reg;
  assign lineDriverStrength = lineDriverStrength_reg;
  assign unlockEventTally = tallyValue;

endmodule
`default_nettype wire

// ==== csr_pkg.sv ====
// Shared constants, types and helpers for the configuration and status register bank.
package csr_pkg;

  localparam int BYTE_W = 8;
  localparam int IDX_W = 3;
  localparam int PIN_ADDR_W = 6;
  localparam int FIELD_W = 7;
  localparam int CURRENT_W = 16;

  localparam logic [IDX_W-1:0] IDX_DRIVE_CFG = 3'h3;
  localparam logic [IDX_W-1:0] IDX_TALLY = 3'h4;
  localparam logic [IDX_W-1:0] IDX_LINK_STATUS = 3'h5;

  localparam int CFG_SRC_BIT = 7;
  localparam int CFG_FIELD_MSB = 6;
  localparam logic [BYTE_W-1:0] DRIVE_CFG_RESET = 8'h00;
  localparam logic [BYTE_W-1:0] TALLY_MAX = 8'hff;
  localparam logic [BYTE_W-1:0] READ_ZERO = 8'h00;
  localparam logic [BYTE_W-IDX_W-1:0] INDEX_PAD = 5'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;

  // Bias current in microamps: base plus field times step.
  localparam logic [CURRENT_W-1:0] BIAS_BASE_UA = 16'h03e8;
  localparam logic [CURRENT_W-1:0] BIAS_STEP_UA = 16'h0190;
  localparam logic [CURRENT_W-1:0] CURRENT_ZERO = 16'h0000;
  localparam logic [FIELD_W-1:0] FIELD_ZERO = 7'h00;

  // Preset pin decode; these codes are plain defaults for the hard-wired pins.
  localparam logic [FIELD_W-1:0] PRESET_CODE_0 = 7'h10;
  localparam logic [FIELD_W-1:0] PRESET_CODE_1 = 7'h20;
  localparam logic [FIELD_W-1:0] PRESET_CODE_2 = 7'h40;
  localparam logic [FIELD_W-1:0] PRESET_CODE_3 = 7'h7f;

  typedef enum logic [1:0] {
    LINK_UNLOCKED = 2'h0,
    LINK_LOCKED = 2'h1,
    LINK_READY = 2'h2,
    LINK_TALLY_SEND = 2'h3
  } csr_link_state_type;

  typedef struct packed {
    csr_link_state_type copyA;
    csr_link_state_type copyB;
    csr_link_state_type copyC;
  } csr_link_copies_type;

  typedef struct packed {
    logic start;
    logic stop;
    logic sclRise;
    logic sclFall;
    logic sdaLevel;
  } csr_line_events_type;

  typedef struct packed {
    logic valid;
    logic dataSlot;
    logic [BYTE_W-1:0] data;
  } csr_bus_write_type;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_WRITE = 7'h08,
    ST_WRITE_ACK = 7'h10,
    ST_READ = 7'h20,
    ST_READ_ACK = 7'h40
  } csr_bus_state_type;

  function automatic logic [FIELD_W-1:0] presetCode(input logic [1:0] pins);
    case (pins)
      2'h0: presetCode = PRESET_CODE_0;
      2'h1: presetCode = PRESET_CODE_1;
      2'h2: presetCode = PRESET_CODE_2;
      default: presetCode = PRESET_CODE_3;
    endcase
  endfunction

endpackage

// ==== csr_line_sampler.sv ====
// Start, stop and clock edge detection on the two serial bus lines.
`timescale 1ns/10ps
`default_nettype none
module csr_line_sampler
  import csr_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic sclIn,
  input wire logic sdaIn,
  output csr_line_events_type events
);

  logic sclPrev_reg;
  logic sdaPrev_reg;

  // Lines are idle high, so reset to high avoids a false stop or clock rise.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end else begin
      sclPrev_reg <= sclIn;
      sdaPrev_reg <= sdaIn;
    end
  end

  always_comb begin
    events.start = sclIn && sclPrev_reg && sdaPrev_reg && !sdaIn;
    events.stop = sclIn && sclPrev_reg && !sdaPrev_reg && sdaIn;
    events.sclRise = sclIn && !sclPrev_reg;
    events.sclFall = !sclIn && sclPrev_reg;
    events.sdaLevel = sdaIn;
  end

endmodule
`default_nettype wire

// ==== csr_unlock_tally.sv ====
// Saturating loss-of-lock tally and its send request when lock returns.
`timescale 1ns/10ps
`default_nettype none
module csr_unlock_tally
  import csr_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic unlockEvent,
  input wire logic lockRegained,
  input wire logic tallySendEnable,
  output logic [BYTE_W-1:0] unlockEventTally,
  output logic tallySendValid,
  output logic [BYTE_W-1:0] tallySendWord
);

  logic [BYTE_W-1:0] tally_reg;
  logic sendValid_reg;
  logic [BYTE_W-1:0] sendWord_reg;

  // Saturation keeps a stormy link from looking healthy after a wrap.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tally_reg <= READ_ZERO;
    end else if (unlockEvent && tally_reg != TALLY_MAX) begin
      tally_reg <= tally_reg + 8'h01;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sendValid_reg <= 1'b0;
      sendWord_reg <= READ_ZERO;
    end else begin
      sendValid_reg <= lockRegained && tallySendEnable;
      if (lockRegained && tallySendEnable) begin
        sendWord_reg <= tally_reg;
      end
    end
  end

  assign unlockEventTally = tally_reg;
  assign tallySendValid = sendValid_reg;
  assign tallySendWord = sendWord_reg;

endmodule
`default_nettype wire

// ==== csr_regs_properties.sv ====
// Timing and value checks on the register bank's drive and tally outputs.
`timescale 1ns/10ps
`default_nettype none
module csr_regs_properties
  import csr_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic laserModePin,
  input wire logic [1:0] biasPresetPins,
  input wire logic unlockEvent,
  input wire logic lockRegained,
  input wire logic tallySendEnable,
  input wire logic regSourceSelect,
  input wire logic [FIELD_W-1:0] laserBiasField,
  input wire logic [CURRENT_W-1:0] biasCurrentUa,
  input wire logic [FIELD_W-1:0] lineDriverStrength,
  input wire logic [BYTE_W-1:0] unlockEventTally,
  input wire logic tallySendValid,
  input wire logic [BYTE_W-1:0] tallySendWord
);
  logic [FIELD_W-1:0] presetExp;
  assign presetExp = (biasPresetPins == 2'h0) ? PRESET_CODE_0 : (biasPresetPins == 2'h1) ? PRESET_CODE_1 :
    (biasPresetPins == 2'h2) ? PRESET_CODE_2 : PRESET_CODE_3;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  // The first edge after reset still sees reset-time outputs, so it is skipped.
  a_preset_source:
  assert property (!$past(reset) && !regSourceSelect && $past(laserModePin) |-> laserBiasField == $past(presetExp))
    else $error("laser field does not follow preset pins");
  a_driver_preset:
  assert property (!$past(reset) && !regSourceSelect && !$past(laserModePin) |->
    lineDriverStrength == $past(presetExp)) else $error("driver strength does not follow preset pins");
  a_bias_formula:
  assert property (!$past(reset) && $past(laserModePin) |->
    biasCurrentUa == BIAS_BASE_UA + CURRENT_W'(laserBiasField) * BIAS_STEP_UA) else $error("bias current wrong");
  a_driver_mode:
  assert property (!$past(reset) && !$past(laserModePin) |-> laserBiasField == FIELD_ZERO &&
    biasCurrentUa == CURRENT_ZERO) else $error("laser outputs active in driver mode");
  a_laser_quiet:
  assert property (!$past(reset) && $past(laserModePin) |-> lineDriverStrength == FIELD_ZERO)
    else $error("driver strength active in laser mode");
  a_tally_step:
  assert property (unlockEvent |=> unlockEventTally == (($past(unlockEventTally) == TALLY_MAX) ? TALLY_MAX :
    $past(unlockEventTally) + 8'h01)) else $error("tally step wrong");
  a_tally_hold:
  assert property (!unlockEvent |=> $stable(unlockEventTally)) else $error("tally moved without event");
  a_send_pulse:
  assert property (lockRegained && tallySendEnable |=> tallySendValid && tallySendWord == $past(unlockEventTally))
    else $error("tally send missing or wrong");
  a_send_quiet:
  assert property (!(lockRegained && tallySendEnable) |=> !tallySendValid) else $error("unexpected tally send");
endmodule
bind csr_config_status_regs csr_regs_properties i_props (
  .core_clk(core_clk), .reset(reset), .laserModePin(laserModePin), .biasPresetPins(biasPresetPins),
  .unlockEvent(unlockEvent), .lockRegained(lockRegained), .tallySendEnable(tallySendEnable),
  .regSourceSelect(regSourceSelect), .laserBiasField(laserBiasField), .biasCurrentUa(biasCurrentUa),
  .lineDriverStrength(lineDriverStrength), .unlockEventTally(unlockEventTally),
  .tallySendValid(tallySendValid), .tallySendWord(tallySendWord)
);
`default_nettype wire

// ==== csr_i2c_master.sv ====
// Behavioural serial bus master with a pulled-up data line.
`timescale 1ns/10ps
`default_nettype none
module csr_i2c_master
(
  input wire logic core_clk,
  input wire logic slvSdaOut,
  input wire logic slvSdaOe,
  output logic sclIn,
  output logic sdaIn
);
  logic sclReg = 1'h1;
  logic sdaReg = 1'h1;
  assign sclIn = sclReg;
  // The line is the wired AND of both parties; releasing means the pull-up wins.
  assign sdaIn = sdaReg & (~slvSdaOe | slvSdaOut);
  task automatic waitq();
    repeat (4) @(posedge core_clk);
  endtask
  task automatic bitIo(input logic b, output logic seen);
    sdaReg <= b;
    waitq();
    sclReg <= 1'h1;
    waitq();
    seen = sdaIn;
    sclReg <= 1'h0;
    waitq();
  endtask
  task automatic startC();
    sdaReg <= 1'h1;
    waitq();
    sclReg <= 1'h1;
    waitq();
    sdaReg <= 1'h0;
    waitq();
    sclReg <= 1'h0;
    waitq();
  endtask
  task automatic stopC();
    sdaReg <= 1'h0;
    waitq();
    sclReg <= 1'h1;
    waitq();
    sdaReg <= 1'h1;
    waitq();
  endtask
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitIo(b[i], s);
    end
    bitIo(1'h1, s);
    ack = ~s;
  endtask
  task automatic recvByte(output logic [7:0] b, input logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitIo(1'h1, b[i]);
    end
    bitIo(nack, s);
  endtask
endmodule
`default_nettype wire

// ==== config_status_regs_i2c_test.sv ====
// Self-checking bench for the register bank through its serial bus.
`timescale 1ns/10ps
`default_nettype none
module config_status_regs_i2c_test
  import csr_pkg::*;
;
  logic core_clk = 1'h0;
  logic reset = 1'h1;
  logic sclIn;
  logic sdaIn;
  logic sdaOut;
  logic sdaOe;
  logic [PIN_ADDR_W-1:0] i2cAddrPins = 6'h31;
  logic laserModePin = 1'h1;
  logic protocolSelectPin = 1'h0;
  logic narrowWordPin = 1'h0;
  logic [1:0] biasPresetPins = 2'h0;
  csr_link_copies_type linkCopies = '0;
  logic unlockEvent = 1'h0;
  logic lockRegained = 1'h0;
  logic tallySendEnable = 1'h0;
  logic regSourceSelect;
  logic [FIELD_W-1:0] laserBiasField;
  logic [CURRENT_W-1:0] biasCurrentUa;
  logic [FIELD_W-1:0] lineDriverStrength;
  logic [BYTE_W-1:0] unlockEventTally;
  logic tallySendValid;
  logic [BYTE_W-1:0] tallySendWord;
  int miscompares = 0;
  int testsRun = 0;
  int cycles = 0;
  logic [FIELD_W-1:0] presetTab[4] = '{PRESET_CODE_0, PRESET_CODE_1, PRESET_CODE_2, PRESET_CODE_3};
  logic [7:0] cfgVals[2] = '{8'h85, 8'hff};
  logic [2:0] badIdx[5] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h7};
  logic ack;
  always #2 core_clk = ~core_clk;
  csr_config_status_regs i_dut (
    .core_clk(core_clk), .reset(reset), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .i2cAddrPins(i2cAddrPins), .laserModePin(laserModePin), .protocolSelectPin(protocolSelectPin),
    .narrowWordPin(narrowWordPin), .biasPresetPins(biasPresetPins), .linkCopies(linkCopies),
    .unlockEvent(unlockEvent), .lockRegained(lockRegained), .tallySendEnable(tallySendEnable),
    .regSourceSelect(regSourceSelect), .laserBiasField(laserBiasField), .biasCurrentUa(biasCurrentUa),
    .lineDriverStrength(lineDriverStrength), .unlockEventTally(unlockEventTally),
    .tallySendValid(tallySendValid), .tallySendWord(tallySendWord)
  );
  csr_i2c_master i_master (
    .core_clk(core_clk), .slvSdaOut(sdaOut), .slvSdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn)
  );
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrIdx(input logic [2:0] idx);
    logic a;
    i_master.startC();
    i_master.sendByte({i2cAddrPins, 2'h0}, a);
    check(16'(a), 16'h0001);
    i_master.sendByte({INDEX_PAD, idx}, a);
    i_master.stopC();
  endtask
  task automatic regWr(input logic [2:0] idx, input logic [7:0] val);
    logic a;
    wrIdx(idx);
    i_master.startC();
    i_master.sendByte({i2cAddrPins, 2'h2}, a);
    i_master.sendByte(val, a);
    i_master.stopC();
  endtask
  task automatic regRd(input logic [2:0] idx, input logic slot, input logic [7:0] exp);
    logic a;
    logic [7:0] v;
    wrIdx(idx);
    i_master.startC();
    i_master.sendByte({i2cAddrPins, slot, 1'h1}, a);
    i_master.recvByte(v, 1'h1);
    i_master.stopC();
    check({8'h00, v}, {8'h00, exp});
  endtask
  task automatic regain(input logic en);
    tallySendEnable <= en;
    lockRegained <= 1'h1;
    @(posedge core_clk);
    lockRegained <= 1'h0;
    @(negedge core_clk);
    check(16'(tallySendValid), 16'(en));
    if (en) begin
      check(16'(tallySendWord), 16'h0003);
    end
    @(posedge core_clk);
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    reset <= 1'h0;
    @(posedge core_clk);
    check(16'(regSourceSelect), 16'h0000);
    regRd(IDX_DRIVE_CFG, 1'h1, DRIVE_CFG_RESET);
    for (int k = 0; k < 4; k++) begin
      biasPresetPins <= 2'(k);
      repeat (3) @(posedge core_clk);
      check(16'(laserBiasField), 16'(presetTab[k]));
      check(biasCurrentUa, BIAS_BASE_UA + 16'(presetTab[k]) * BIAS_STEP_UA);
    end
    // Line driver mode with the pins still in charge.
    laserModePin <= 1'h0;
    repeat (3) @(posedge core_clk);
    check(16'(lineDriverStrength), 16'(presetTab[3]));
    check(16'(laserBiasField), 16'h0000);
    laserModePin <= 1'h1;
    $display("test preset sourcing done");
    for (int k = 0; k < 2; k++) begin
      regWr(IDX_DRIVE_CFG, cfgVals[k]);
      repeat (2) @(posedge core_clk);
      check(16'(regSourceSelect), 16'h0001);
      check(16'(laserBiasField), 16'(cfgVals[k][6:0]));
      check(biasCurrentUa, BIAS_BASE_UA + 16'(cfgVals[k][6:0]) * BIAS_STEP_UA);
      regRd(IDX_DRIVE_CFG, 1'h1, cfgVals[k]);
    end
    laserModePin <= 1'h0;
    repeat (3) @(posedge core_clk);
    check(16'(lineDriverStrength), 16'h007f);
    check(biasCurrentUa, CURRENT_ZERO);
    laserModePin <= 1'h1;
    $display("test register sourcing done");
    // Neighbouring copies differ so a swapped field order cannot pass.
    for (int k = 0; k < 4; k++) begin
      linkCopies <= csr_link_copies_type'({2'(k), 2'(k + 1), 2'(k + 2)});
      protocolSelectPin <= k[0];
      narrowWordPin <= k[1];
      regRd(IDX_LINK_STATUS, 1'h1, {2'(k), 2'(k + 1), 2'(k + 2), k[0], k[1]});
    end
    regWr(IDX_LINK_STATUS, 8'h00);
    regRd(IDX_LINK_STATUS, 1'h1, 8'hc7);
    regWr(IDX_TALLY, 8'haa);
    regRd(IDX_TALLY, 1'h1, 8'h00);
    for (int k = 0; k < 5; k++) begin
      regWr(badIdx[k], 8'h5a);
      regRd(badIdx[k], 1'h1, READ_ZERO);
    end
    regRd(IDX_DRIVE_CFG, 1'h1, 8'hff);
    regRd(3'h6, 1'h0, 8'h06);
    i_master.startC();
    i_master.sendByte({~i2cAddrPins, 2'h0}, ack);
    i_master.stopC();
    check(16'(ack), 16'h0000);
    $display("test status and index done");
    for (int k = 0; k < 3; k++) begin
      unlockEvent <= 1'h1;
      @(posedge core_clk);
      unlockEvent <= 1'h0;
      @(posedge core_clk);
    end
    regRd(IDX_TALLY, 1'h1, 8'h03);
    regain(1'h1);
    regain(1'h0);
    unlockEvent <= 1'h1;
    repeat (260) @(posedge core_clk);
    unlockEvent <= 1'h0;
    regRd(IDX_TALLY, 1'h1, TALLY_MAX);
    $display("test tally done");
    report_and_stop();
  end
endmodule
`default_nettype wire
